// ### hw/timer_pair_pkg.sv
package timer_pair_pkg;

    // ------------------------------------------------------------
    // Special function register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'h88;
    localparam logic [7:0] ADDR_MODE      = 8'h89;
    localparam logic [7:0] ADDR_A_LOW     = 8'h8A;
    localparam logic [7:0] ADDR_B_LOW     = 8'h8B;
    localparam logic [7:0] ADDR_A_HIGH    = 8'h8C;
    localparam logic [7:0] ADDR_B_HIGH    = 8'h8D;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] MODE_RESET     = 8'h00;
    localparam logic [7:0] COUNT_RESET    = 8'h00;
    localparam logic [7:0] READ_IDLE      = 8'h00;

    // ------------------------------------------------------------
    // Control register bits
    // ------------------------------------------------------------
    localparam int CTRL_B_OVF      = 7;
    localparam int CTRL_B_RUN      = 6;
    localparam int CTRL_A_OVF      = 5;
    localparam int CTRL_A_RUN      = 4;
    localparam int CTRL_IRQB_FLAG  = 3;
    localparam int CTRL_IRQB_TYPE  = 2;
    localparam int CTRL_IRQA_FLAG  = 1;
    localparam int CTRL_IRQA_TYPE  = 0;

    // ------------------------------------------------------------
    // Mode register bits
    // ------------------------------------------------------------
    localparam int MODE_B_GATE     = 7;
    localparam int MODE_B_CT       = 6;
    localparam int MODE_B_FIELD    = 4;
    localparam int MODE_A_GATE     = 3;
    localparam int MODE_A_CT       = 2;
    localparam int MODE_A_FIELD    = 0;
    localparam int FIELD_WIDTH     = 2;

    // ------------------------------------------------------------
    // Counting geometry and timing
    // ------------------------------------------------------------
    localparam int         PRESCALE_BITS   = 5;
    localparam logic [7:0] BYTE_ALL_ONES   = 8'hFF;
    localparam int         OSC_PER_MACHINE = 12;
    localparam logic [3:0] DIV_LAST        = 4'(OSC_PER_MACHINE - 1);
    localparam logic [3:0] DIV_ZERO        = 4'h0;
    localparam logic [3:0] DIV_STEP        = 4'h1;

    typedef enum logic [1:0] {
        MODE_13BIT   = 2'b00,
        MODE_16BIT   = 2'b01,
        MODE_RELOAD8 = 2'b10,
        MODE_SPLIT   = 2'b11
    } mode_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic timer_a;
        logic timer_b;
        logic ext_irq_a;
        logic ext_irq_b;
    } vector_ack_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic       ovf;
    } count_res_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sample;
        logic fall;
    } sampler_state_t;

    typedef struct packed {
        logic [3:0] div;
        logic       tick;
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [7:0] a_hi;
        logic [7:0] a_lo;
        logic [7:0] b_hi;
        logic [7:0] b_lo;
        logic [7:0] rdata;
        logic       b_roll;
    } timer_state_t;

endpackage

// ### hw/pin_edge_sampler.sv
`timescale 1ns/1ps
module pin_edge_sampler
(
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic tick_in,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      fall_out
);

    timer_pair_pkg::sampler_state_t s_q;
    timer_pair_pkg::sampler_state_t s_d;

    // ------------------------------------------------------------
    // Synchroniser and machine-cycle sampling
    // ------------------------------------------------------------
    always_comb
    begin
        s_d       = s_q;
        s_d.sync1 = pin_in;
        s_d.sync2 = s_q.sync1;
        s_d.fall  = 1'b0;
        if (tick_in)
        begin
            s_d.sample = s_q.sync2;
            s_d.fall   = s_q.sample & ~s_q.sync2;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            s_q <= '{sync1: 1'b1, sync2: 1'b1, sample: 1'b1, fall: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign level_out = s_q.sync2;
    assign fall_out  = s_q.fall;

endmodule

// ### hw/dual_timer_counter_pair.sv
`timescale 1ns/1ps
module dual_timer_counter_pair
(
    input  wire logic                        clk_in,
    input  wire logic                        reset_in,
    input  wire timer_pair_pkg::sfr_req_t    sfr_req_in,
    input  wire timer_pair_pkg::vector_ack_t vector_ack_in,
    input  wire logic                        count_pin_a_in,
    input  wire logic                        count_pin_b_in,
    input  wire logic                        ext_irq_pin_a_in,
    input  wire logic                        ext_irq_pin_b_in,
    output logic [7:0]                       sfr_rdata_out,
    output logic                             timer_a_overflow_flag_out,
    output logic                             timer_b_overflow_flag_out,
    output logic                             ext_irq_a_edge_flag_out,
    output logic                             ext_irq_b_edge_flag_out,
    output logic                             timer_b_rollover_pulse_out
);

    timer_pair_pkg::timer_state_t st_q;
    timer_pair_pkg::timer_state_t st_d;

    logic pin_a_fall;
    logic pin_b_fall;
    logic irq_a_level;
    logic irq_a_fall;
    logic irq_b_level;
    logic irq_b_fall;

    // ------------------------------------------------------------
    // Pin samplers
    // ------------------------------------------------------------
    pin_edge_sampler u_count_a
    (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .tick_in   (st_q.tick),
        .pin_in    (count_pin_a_in),
        .level_out (),
        .fall_out  (pin_a_fall)
    );

    pin_edge_sampler u_count_b
    (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .tick_in   (st_q.tick),
        .pin_in    (count_pin_b_in),
        .level_out (),
        .fall_out  (pin_b_fall)
    );

    pin_edge_sampler u_irq_a
    (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .tick_in   (st_q.tick),
        .pin_in    (ext_irq_pin_a_in),
        .level_out (irq_a_level),
        .fall_out  (irq_a_fall)
    );

    pin_edge_sampler u_irq_b
    (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .tick_in   (st_q.tick),
        .pin_in    (ext_irq_pin_b_in),
        .level_out (irq_b_level),
        .fall_out  (irq_b_fall)
    );

    // ------------------------------------------------------------
    // One counting step for a timer pair of bytes
    // ------------------------------------------------------------
    function automatic timer_pair_pkg::count_res_t step_count
    (
        input timer_pair_pkg::mode_t m,
        input logic [7:0]            hi,
        input logic [7:0]            lo,
        input logic                  inc
    );
        timer_pair_pkg::count_res_t r;
        logic [13:0]                s13;
        logic [16:0]                s16;
        logic [8:0]                 s8;
        r   = '{hi: hi, lo: lo, ovf: 1'b0};
        s13 = {1'b0, hi, lo[timer_pair_pkg::PRESCALE_BITS-1:0]} + 14'h0001;
        s16 = {1'b0, hi, lo} + 17'h0_0001;
        s8  = {1'b0, lo} + 9'h001;
        if (inc)
        begin
            case (m)
                timer_pair_pkg::MODE_13BIT:
                begin
                    r.hi  = s13[12:5];
                    r.lo  = {lo[7:timer_pair_pkg::PRESCALE_BITS],
                             s13[timer_pair_pkg::PRESCALE_BITS-1:0]};
                    r.ovf = s13[13];
                end
                timer_pair_pkg::MODE_16BIT:
                begin
                    r.hi  = s16[15:8];
                    r.lo  = s16[7:0];
                    r.ovf = s16[16];
                end
                timer_pair_pkg::MODE_RELOAD8:
                begin
                    if (lo == timer_pair_pkg::BYTE_ALL_ONES)
                    begin
                        r.lo  = hi;
                        r.ovf = 1'b1;
                    end
                    else
                    begin
                        r.lo = s8[7:0];
                    end
                end
                default:
                begin
                    // Plain 8-bit low counter, used by the split mode
                    r.lo  = s8[7:0];
                    r.ovf = s8[8];
                end
            endcase
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        timer_pair_pkg::mode_t      mode_a;
        timer_pair_pkg::mode_t      mode_b;
        timer_pair_pkg::count_res_t res_a;
        timer_pair_pkg::count_res_t res_b;
        timer_pair_pkg::count_res_t res_ah;
        logic                       en_a;
        logic                       en_b;
        logic                       inc_a;
        logic                       inc_b;
        logic                       inc_ah;
        logic                       split;
        logic                       a_ovf_set;
        logic                       b_ovf_set;

        st_d   = st_q;
        res_a     = '0;
        res_b     = '0;
        res_ah    = '0;
        en_a      = 1'b0;
        en_b      = 1'b0;
        inc_a     = 1'b0;
        inc_b     = 1'b0;
        inc_ah    = 1'b0;
        a_ovf_set = 1'b0;
        b_ovf_set = 1'b0;
        mode_a = timer_pair_pkg::mode_t'(
            st_q.mode[timer_pair_pkg::MODE_A_FIELD +: timer_pair_pkg::FIELD_WIDTH]);
        mode_b = timer_pair_pkg::mode_t'(
            st_q.mode[timer_pair_pkg::MODE_B_FIELD +: timer_pair_pkg::FIELD_WIDTH]);
        split  = (mode_a == timer_pair_pkg::MODE_SPLIT);

        // Machine cycle divider
        st_d.tick = 1'b0;
        if (st_q.div == timer_pair_pkg::DIV_LAST)
        begin
            st_d.div  = timer_pair_pkg::DIV_ZERO;
            st_d.tick = 1'b1;
        end
        else
        begin
            st_d.div = st_q.div + timer_pair_pkg::DIV_STEP;
        end

        // Count enables and sources
        en_a = st_q.ctrl[timer_pair_pkg::CTRL_A_RUN]
             & (~st_q.mode[timer_pair_pkg::MODE_A_GATE] | irq_a_level);
        inc_a = en_a & (st_q.mode[timer_pair_pkg::MODE_A_CT] ? pin_a_fall
                                                             : st_q.tick);

        en_b = (~st_q.mode[timer_pair_pkg::MODE_B_GATE] | irq_b_level)
             & (mode_b != timer_pair_pkg::MODE_SPLIT);
        if (!split)
        begin
            en_b = en_b & st_q.ctrl[timer_pair_pkg::CTRL_B_RUN];
        end
        // With A split, B's run bit belongs to A's high byte
        inc_b = en_b & (st_q.mode[timer_pair_pkg::MODE_B_CT] ? pin_b_fall
                                                             : st_q.tick);

        inc_ah = split & st_q.ctrl[timer_pair_pkg::CTRL_B_RUN] & st_q.tick;

        // Counting, edge counts land in the cycle after detection
        res_a  = step_count(mode_a, st_q.a_hi, st_q.a_lo, inc_a);
        res_b  = step_count(mode_b, st_q.b_hi, st_q.b_lo, inc_b);
        res_ah = step_count(timer_pair_pkg::MODE_SPLIT, 8'h00, st_q.a_hi, inc_ah);

        st_d.a_lo = res_a.lo;
        st_d.a_hi = split ? res_ah.lo : res_a.hi;
        st_d.b_lo = res_b.lo;
        st_d.b_hi = res_b.hi;
        st_d.b_roll = res_b.ovf;

        a_ovf_set = res_a.ovf;
        b_ovf_set = split ? res_ah.ovf : res_b.ovf;

        // Interrupt vector acknowledgements
        if (vector_ack_in.timer_a)
        begin
            st_d.ctrl[timer_pair_pkg::CTRL_A_OVF] = 1'b0;
        end
        if (vector_ack_in.timer_b)
        begin
            st_d.ctrl[timer_pair_pkg::CTRL_B_OVF] = 1'b0;
        end
        if (vector_ack_in.ext_irq_a)
        begin
            st_d.ctrl[timer_pair_pkg::CTRL_IRQA_FLAG] = 1'b0;
        end
        if (vector_ack_in.ext_irq_b)
        begin
            st_d.ctrl[timer_pair_pkg::CTRL_IRQB_FLAG] = 1'b0;
        end

        // Software writes; counts are never cleared by the run bit
        if (sfr_req_in.wr)
        begin
            case (sfr_req_in.addr)
                timer_pair_pkg::ADDR_CTRL:   st_d.ctrl = sfr_req_in.wdata;
                timer_pair_pkg::ADDR_MODE:   st_d.mode = sfr_req_in.wdata;
                timer_pair_pkg::ADDR_A_LOW:  st_d.a_lo = sfr_req_in.wdata;
                timer_pair_pkg::ADDR_A_HIGH: st_d.a_hi = sfr_req_in.wdata;
                timer_pair_pkg::ADDR_B_LOW:  st_d.b_lo = sfr_req_in.wdata;
                timer_pair_pkg::ADDR_B_HIGH: st_d.b_hi = sfr_req_in.wdata;
                default:                     st_d.ctrl = st_d.ctrl;
            endcase
        end

        // Hardware sets win over any clear
        if (a_ovf_set)
        begin
            st_d.ctrl[timer_pair_pkg::CTRL_A_OVF] = 1'b1;
        end
        if (b_ovf_set)
        begin
            st_d.ctrl[timer_pair_pkg::CTRL_B_OVF] = 1'b1;
        end

        if (st_q.ctrl[timer_pair_pkg::CTRL_IRQA_TYPE])
        begin
            if (irq_a_fall)
            begin
                st_d.ctrl[timer_pair_pkg::CTRL_IRQA_FLAG] = 1'b1;
            end
        end
        else
        begin
            st_d.ctrl[timer_pair_pkg::CTRL_IRQA_FLAG] = ~irq_a_level;
        end

        if (st_q.ctrl[timer_pair_pkg::CTRL_IRQB_TYPE])
        begin
            if (irq_b_fall)
            begin
                st_d.ctrl[timer_pair_pkg::CTRL_IRQB_FLAG] = 1'b1;
            end
        end
        else
        begin
            st_d.ctrl[timer_pair_pkg::CTRL_IRQB_FLAG] = ~irq_b_level;
        end

        // Registered read data, zero on unmapped addresses
        case (sfr_req_in.addr)
            timer_pair_pkg::ADDR_CTRL:   st_d.rdata = st_q.ctrl;
            timer_pair_pkg::ADDR_MODE:   st_d.rdata = st_q.mode;
            timer_pair_pkg::ADDR_A_LOW:  st_d.rdata = st_q.a_lo;
            timer_pair_pkg::ADDR_A_HIGH: st_d.rdata = st_q.a_hi;
            timer_pair_pkg::ADDR_B_LOW:  st_d.rdata = st_q.b_lo;
            timer_pair_pkg::ADDR_B_HIGH: st_d.rdata = st_q.b_hi;
            default:                     st_d.rdata = timer_pair_pkg::READ_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            st_q.div    <= timer_pair_pkg::DIV_ZERO;
            st_q.tick   <= 1'b0;
            st_q.ctrl   <= timer_pair_pkg::CTRL_RESET;
            st_q.mode   <= timer_pair_pkg::MODE_RESET;
            st_q.a_hi   <= timer_pair_pkg::COUNT_RESET;
            st_q.a_lo   <= timer_pair_pkg::COUNT_RESET;
            st_q.b_hi   <= timer_pair_pkg::COUNT_RESET;
            st_q.b_lo   <= timer_pair_pkg::COUNT_RESET;
            st_q.rdata  <= timer_pair_pkg::READ_IDLE;
            st_q.b_roll <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sfr_rdata_out              = st_q.rdata;
    assign timer_a_overflow_flag_out  = st_q.ctrl[timer_pair_pkg::CTRL_A_OVF];
    assign timer_b_overflow_flag_out  = st_q.ctrl[timer_pair_pkg::CTRL_B_OVF];
    assign ext_irq_a_edge_flag_out    = st_q.ctrl[timer_pair_pkg::CTRL_IRQA_FLAG];
    assign ext_irq_b_edge_flag_out    = st_q.ctrl[timer_pair_pkg::CTRL_IRQB_FLAG];
    assign timer_b_rollover_pulse_out = st_q.b_roll;

endmodule

// ### tb/timer_pair_monitor.sv
`timescale 1ns/1ps
module timer_pair_monitor
(
    input  wire logic                        clk_in,
    input  wire logic                        reset_in,
    input  wire timer_pair_pkg::sfr_req_t    sfr_req_in,
    input  wire timer_pair_pkg::vector_ack_t vector_ack_in,
    input  wire logic                        count_pin_a_in,
    input  wire logic                        count_pin_b_in,
    input  wire logic                        ext_irq_pin_a_in,
    input  wire logic                        ext_irq_pin_b_in,
    input  wire logic [7:0]                  sfr_rdata_out,
    input  wire logic                        timer_a_overflow_flag_out,
    input  wire logic                        timer_b_overflow_flag_out,
    input  wire logic                        ext_irq_a_edge_flag_out,
    input  wire logic                        ext_irq_b_edge_flag_out,
    input  wire logic                        timer_b_rollover_pulse_out
);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    logic ctrl_wr;
    logic mapped;
    assign ctrl_wr = sfr_req_in.wr && (sfr_req_in.addr == timer_pair_pkg::ADDR_CTRL);
    assign mapped  = (sfr_req_in.addr >= timer_pair_pkg::ADDR_CTRL)
                  && (sfr_req_in.addr <= timer_pair_pkg::ADDR_B_HIGH);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_flag_clear_a: assert property ($fell(timer_a_overflow_flag_out) |->
        $past(vector_ack_in.timer_a || ctrl_wr || reset_in)) else $error("timer a flag lost");
    b_flag_clear_a: assert property ($fell(timer_b_overflow_flag_out) |->
        $past(vector_ack_in.timer_b || ctrl_wr || reset_in)) else $error("timer b flag lost");
    roll_spacing_a: assert property (timer_b_rollover_pulse_out |=>
        !timer_b_rollover_pulse_out [*8]) else $error("rollover pulses too close");
    irq_a_quiet_a: assert property ((ext_irq_pin_a_in [*7] ##0 !$past(ctrl_wr)) |->
        !$rose(ext_irq_a_edge_flag_out)) else $error("irq a flag without edge");
    irq_b_quiet_a: assert property ((ext_irq_pin_b_in [*7] ##0 !$past(ctrl_wr)) |->
        !$rose(ext_irq_b_edge_flag_out)) else $error("irq b flag without edge");
    reset_clear_a: assert property ($past(reset_in) |-> (sfr_rdata_out == 8'h00)
        && !timer_a_overflow_flag_out && !timer_b_overflow_flag_out && !ext_irq_a_edge_flag_out
        && !ext_irq_b_edge_flag_out && !timer_b_rollover_pulse_out) else $error("reset state");
    unmapped_zero_a: assert property (!mapped |=>
        sfr_rdata_out == timer_pair_pkg::READ_IDLE) else $error("unmapped read not zero");
    mode_readback_a: assert property ((sfr_req_in.wr && sfr_req_in.addr == 8'h89) ##1
        (!sfr_req_in.wr && sfr_req_in.addr == 8'h89) |=> sfr_rdata_out == $past(sfr_req_in.wdata, 2))
        else $error("mode readback");

    cover property ($rose(timer_a_overflow_flag_out));
    cover property (timer_b_rollover_pulse_out);
    cover property ($rose(ext_irq_b_edge_flag_out));
endmodule

bind dual_timer_counter_pair timer_pair_monitor u_mon
(
    .clk_in(clk_in), .reset_in(reset_in), .sfr_req_in(sfr_req_in),
    .vector_ack_in(vector_ack_in), .count_pin_a_in(count_pin_a_in),
    .count_pin_b_in(count_pin_b_in), .ext_irq_pin_a_in(ext_irq_pin_a_in),
    .ext_irq_pin_b_in(ext_irq_pin_b_in), .sfr_rdata_out(sfr_rdata_out),
    .timer_a_overflow_flag_out(timer_a_overflow_flag_out),
    .timer_b_overflow_flag_out(timer_b_overflow_flag_out),
    .ext_irq_a_edge_flag_out(ext_irq_a_edge_flag_out),
    .ext_irq_b_edge_flag_out(ext_irq_b_edge_flag_out),
    .timer_b_rollover_pulse_out(timer_b_rollover_pulse_out)
);

// ### tb/pin_source_model.sv
`timescale 1ns/1ps
module pin_source_model
(
    input  wire logic  clk_in,
    output logic [3:0] pins_out
);
    // ------------------------------------------------------------
    // Pins: count a, count b, irq a, irq b; idle high
    // ------------------------------------------------------------
    initial pins_out = 4'hF;

    task automatic count_pulses(input int idx, input int n, input int hold);
        repeat (n)
        begin
            repeat (hold) @(posedge clk_in);
            pins_out[idx] <= 1'b0;
            repeat (hold) @(posedge clk_in);
            pins_out[idx] <= 1'b1;
        end
    endtask

    task automatic set_pin(input int idx, input logic lvl);
        @(posedge clk_in);
        pins_out[idx] <= lvl;
    endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic                        clk_in      = 1'b0;
    logic                        reset_in    = 1'b1;
    timer_pair_pkg::sfr_req_t    sfr_req     = '0;
    timer_pair_pkg::vector_ack_t ack         = '0;
    logic [3:0]                  pins;
    logic [7:0]                  rdata;
    wire  [4:0]                  flags;
    logic [7:0]                  v;
    int                          n;
    int                          failures    = 0;
    int                          comparisons = 0;
    int                          cycles      = 0;

    always #2.5 clk_in = ~clk_in;

    pin_source_model partner (.clk_in(clk_in), .pins_out(pins));

    dual_timer_counter_pair dut
    (
        .clk_in(clk_in), .reset_in(reset_in), .sfr_req_in(sfr_req), .vector_ack_in(ack),
        .count_pin_a_in(pins[0]), .count_pin_b_in(pins[1]),
        .ext_irq_pin_a_in(pins[2]), .ext_irq_pin_b_in(pins[3]), .sfr_rdata_out(rdata),
        .timer_a_overflow_flag_out(flags[0]), .timer_b_overflow_flag_out(flags[1]),
        .ext_irq_a_edge_flag_out(flags[2]), .ext_irq_b_edge_flag_out(flags[3]),
        .timer_b_rollover_pulse_out(flags[4])
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            failures++;
            report_and_stop();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Clocks between auto-reload overflows for a preset
    function automatic int reload_period(input logic [7:0] preset);
        return (256 - int'(preset)) * timer_pair_pkg::OSC_PER_MACHINE;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        sfr_req <= '{1'b1, a, d};
        @(posedge clk_in);
        sfr_req <= '{1'b0, a, d};
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        sfr_req <= '{1'b0, a, 8'h00};
        @(posedge clk_in);
        #1 check(rdata, exp);
    endtask

    task automatic pulse_ack(input int idx);
        @(posedge clk_in);
        ack[idx] <= 1'b1;
        @(posedge clk_in);
        ack <= '0;
    endtask

    // Waits for a flag, stopping early once it is seen
    task automatic wait_for(input int idx, input int limit, input logic want);
        logic hit;
        int   c;
        hit = 1'b0;
        c = 0;
        while (c < limit && !hit)
        begin
            @(posedge clk_in);
            #1 hit = (flags[idx] === 1'b1);
            c++;
        end
        check(8'(hit), 8'(want));
    endtask

    task automatic gap(output int c);
        c = 0;
        do
        begin
            @(posedge clk_in);
            #1 c++;
        end
        while (flags[4] !== 1'b1 && c < 400);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        void'($urandom(95110));
        for (int a = 8'h88; a <= 8'h8D; a++)
            rc(8'(a), 8'h00);
        rc(8'(8'h90 + $urandom_range(0, 100)), 8'h00);
        v = 8'($urandom);
        wr(timer_pair_pkg::ADDR_MODE, v);
        rc(timer_pair_pkg::ADDR_MODE, v);
        v = 8'($urandom) & 8'h55;
        wr(timer_pair_pkg::ADDR_CTRL, v);
        rc(timer_pair_pkg::ADDR_CTRL, v);
        wr(timer_pair_pkg::ADDR_CTRL, 8'h00);
        for (int m = 0; m < 2; m++)
        begin
            wr(timer_pair_pkg::ADDR_MODE, 8'(m));
            wr(timer_pair_pkg::ADDR_A_HIGH, 8'hFF);
            wr(timer_pair_pkg::ADDR_A_LOW, (m == 1) ? 8'hFF : 8'h1F);
            wr(timer_pair_pkg::ADDR_CTRL, 8'h10);
            wait_for(0, 14, 1'b1);
            rc(timer_pair_pkg::ADDR_A_HIGH, 8'h00);
            rc(timer_pair_pkg::ADDR_A_LOW, 8'h00);
            pulse_ack(3);
            wait_for(0, 3, 1'b0);
            wr(timer_pair_pkg::ADDR_CTRL, 8'h00);
        end
        for (int k = 0; k < 3; k++)
        begin
            partner.set_pin(2, k != 0);
            wr(timer_pair_pkg::ADDR_MODE, (k == 1) ? 8'h01 : 8'h09);
            wr(timer_pair_pkg::ADDR_A_HIGH, 8'hFF);
            wr(timer_pair_pkg::ADDR_A_LOW, 8'hFF);
            wr(timer_pair_pkg::ADDR_CTRL, (k == 1) ? 8'h00 : 8'h10);
            wait_for(0, (k == 2) ? 20 : 40, k == 2);
            rc(timer_pair_pkg::ADDR_A_HIGH, (k == 2) ? 8'h00 : 8'hFF);
            wr(timer_pair_pkg::ADDR_CTRL, 8'h00);
        end
        for (int s = 0; s < 2; s++)
        begin
            n = $urandom_range(1, 9);
            wr(timer_pair_pkg::ADDR_MODE, (s == 1) ? 8'h50 : 8'h05);
            wr((s == 1) ? timer_pair_pkg::ADDR_B_LOW : timer_pair_pkg::ADDR_A_LOW, 8'h00);
            wr(timer_pair_pkg::ADDR_CTRL, (s == 1) ? 8'h40 : 8'h10);
            partner.count_pulses(s, n, 12);
            repeat (40) @(posedge clk_in);
            rc((s == 1) ? timer_pair_pkg::ADDR_B_LOW : timer_pair_pkg::ADDR_A_LOW, 8'(n));
            wr(timer_pair_pkg::ADDR_CTRL, 8'h00);
        end
        wr(timer_pair_pkg::ADDR_MODE, 8'hA0);
        wr(timer_pair_pkg::ADDR_B_HIGH, 8'hF0);
        wr(timer_pair_pkg::ADDR_B_LOW, 8'hF0);
        wr(timer_pair_pkg::ADDR_CTRL, 8'h40);
        gap(n);
        gap(n);
        check(8'(n == reload_period(8'hF0)), 8'h01);
        rc(timer_pair_pkg::ADDR_B_LOW, 8'hF0);
        rc(timer_pair_pkg::ADDR_B_HIGH, 8'hF0);
        pulse_ack(2);
        wait_for(1, 3, 1'b0);
        wr(timer_pair_pkg::ADDR_CTRL, 8'h00);
        wr(timer_pair_pkg::ADDR_A_HIGH, 8'h00);
        wr(timer_pair_pkg::ADDR_A_LOW, 8'h00);
        wr(timer_pair_pkg::ADDR_B_HIGH, 8'hFF);
        wr(timer_pair_pkg::ADDR_B_LOW, 8'h1F);
        wr(timer_pair_pkg::ADDR_MODE, 8'h03);
        wait_for(4, 14, 1'b1);
        wait_for(1, 3, 1'b0);
        wr(timer_pair_pkg::ADDR_CTRL, 8'h40);
        wr(timer_pair_pkg::ADDR_A_HIGH, 8'hFF);
        wait_for(1, 14, 1'b1);
        rc(timer_pair_pkg::ADDR_A_LOW, 8'h00);
        wr(timer_pair_pkg::ADDR_MODE, 8'h33);
        wr(timer_pair_pkg::ADDR_B_LOW, 8'h42);
        repeat (30) @(posedge clk_in);
        rc(timer_pair_pkg::ADDR_B_LOW, 8'h42);
        for (int s = 0; s < 2; s++)
        begin
            wr(timer_pair_pkg::ADDR_CTRL, (s == 1) ? 8'h04 : 8'h01);
            partner.set_pin(2 + s, 1'b0);
            wait_for(2 + s, 40, 1'b1);
            partner.set_pin(2 + s, 1'b1);
            pulse_ack(1 - s);
            repeat (20) @(posedge clk_in);
            check(8'(flags[2 + s]), 8'h00);
            wr(timer_pair_pkg::ADDR_CTRL, 8'h00);
            partner.set_pin(2 + s, 1'b0);
            wait_for(2 + s, 20, 1'b1);
            partner.set_pin(2 + s, 1'b1);
            repeat (20) @(posedge clk_in);
            check(8'(flags[2 + s]), 8'h00);
        end
        report_and_stop();
    end
endmodule
